// *** rtl/src_pkg.sv ***
// Purpose: Shared constants and types for the system reset controller
// Assumes: Classic Wishbone slave, 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses inside the control register frame
package src_pkg;

    // Bus geometry
    localparam int          DATA_W         = 32;
    localparam int          ADDR_W         = 8;
    localparam int          SEL_W          = DATA_W / 8;

    // Register map
    localparam logic [7:0]  OFS_SYS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_CAUSE      = 8'h04;
    localparam logic [7:0]  OFS_WD_CTRL    = 8'h08;
    localparam logic [7:0]  OFS_WD_KEY     = 8'h0C;
    localparam logic [7:0]  OFS_WD_COUNT   = 8'h10;
    localparam logic [7:0]  OFS_CPU_IMAGE  = 8'h14;

    // System control register
    localparam int          SCR_KEEP_BIT   = 14;
    localparam int          SCR_FORCE_BIT  = 15;
    localparam logic [15:0] SCR_RST        = 16'h4000;

    // Reset cause bit positions
    localparam int          CAUSE_WD       = 0;
    localparam int          CAUSE_SW       = 1;
    localparam int          CAUSE_POR      = 2;
    localparam int          CAUSE_ILL      = 3;
    localparam int          CAUSE_PIN      = 4;
    localparam int          CAUSE_W        = 5;

    // Reset pin stretch, in system clock cycles
    localparam int          STRETCH_W      = 4;
    localparam logic [3:0]  STRETCH_CYCLES = 4'h8;
    localparam int          DRIVE_DLY_W    = 2;

    // Watchdog
    localparam int          WD_CNT_W       = 8;
    localparam logic [7:0]  WD_KEY_FIRST   = 8'h55;
    localparam logic [7:0]  WD_KEY_SECOND  = 8'hAA;
    localparam int          WD_CHECK_LSB   = 3;
    localparam logic [2:0]  WD_CHECK_VAL   = 3'h5;
    localparam int          WD_DISABLE_BIT = 6;
    localparam logic [7:0]  WD_CTRL_RST    = 8'h28;

    typedef enum logic [1:0] {
        WDK_FIRST  = 2'b01,
        WDK_SECOND = 2'b10
    } src_wdkey_t;

    // CPU reset image
    localparam logic [2:0]  WAIT_MAX       = 3'h7;

    typedef struct packed {
        logic [15:0] progCounter;
        logic        ramBlockMap;
        logic        globalIntMask;
        logic [15:0] intFlag;
        logic [15:0] intMask;
        logic        arithWrap;
        logic        extFlagOut;
        logic        signExtend;
        logic [1:0]  productShift;
        logic        carry;
        logic [7:0]  globalMemAlloc;
        logic [15:0] repeatCounter;
        logic [2:0]  waitStates;
    } src_cpu_init_t;

    localparam src_cpu_init_t CPU_INIT = '{
        progCounter:    16'h0000,
        ramBlockMap:    1'b0,
        globalIntMask:  1'b1,
        intFlag:        16'h0000,
        intMask:        16'h0000,
        arithWrap:      1'b0,
        extFlagOut:     1'b1,
        signExtend:     1'b1,
        productShift:   2'h0,
        carry:          1'b1,
        globalMemAlloc: 8'h00,
        repeatCounter:  16'h0000,
        waitStates:     WAIT_MAX
    };

    typedef struct packed {
        logic pin;
        logic illegal;
        logic powerOn;
        logic software;
        logic watchdog;
    } src_cause_t;

endpackage

// *** rtl/src_watchdog.sv ***
// Purpose: Watchdog counter with key and control checks
// Assumes: Written values arrive as one-cycle strobes from the register slave
// Notes:   Held cleared while the system reset is active
`timescale 1ns/1ps
module src_watchdog #(
    parameter int CNT_W = src_pkg::WD_CNT_W
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             sysReset,
    // Register strobes
    input  wire logic             ctrlWrite,
    input  wire logic             keyWrite,
    input  wire logic [7:0]       wrData,
    // Status
    output logic      [7:0]       ctrlValue,
    output logic      [CNT_W-1:0] count,
    output logic                  fire
);

    typedef struct packed {
        logic [CNT_W-1:0]   count;
        logic [7:0]         ctrl;
        src_pkg::src_wdkey_t key;
        logic               fire;
    } src_wd_state_t;

    localparam src_wd_state_t WD_RST = '{
        count: '0,
        ctrl:  src_pkg::WD_CTRL_RST,
        key:   src_pkg::WDK_FIRST,
        fire:  1'b0
    };

    src_wd_state_t q;
    src_wd_state_t d;

    always_comb begin
        d      = q;
        d.fire = 1'b0;
        if (sysReset) begin
            d = WD_RST;
        end else begin
            // Runs from power-on with no software action
            if (!q.ctrl[src_pkg::WD_DISABLE_BIT]) begin
                if (&q.count) begin
                    d.fire = 1'b1;
                end else begin
                    d.count = q.count + 1'b1;
                end
            end
            if (ctrlWrite) begin
                if (wrData[src_pkg::WD_CHECK_LSB +: 3] != src_pkg::WD_CHECK_VAL) begin
                    d.fire = 1'b1;
                end else begin
                    d.ctrl = wrData;
                end
            end
            if (keyWrite) begin
                unique case (q.key)
                    src_pkg::WDK_FIRST: begin
                        if (wrData == src_pkg::WD_KEY_FIRST) begin
                            d.key = src_pkg::WDK_SECOND;
                        end else begin
                            d.fire = 1'b1;
                        end
                    end
                    src_pkg::WDK_SECOND: begin
                        if (wrData == src_pkg::WD_KEY_SECOND) begin
                            d.count = '0;
                            d.key   = src_pkg::WDK_FIRST;
                        end else if (wrData != src_pkg::WD_KEY_FIRST) begin
                            d.fire = 1'b1;
                        end
                    end
                    default: begin
                        d.key = src_pkg::WDK_FIRST;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            q <= WD_RST;
        end else begin
            q <= d;
        end
    end

    assign ctrlValue = q.ctrl;
    assign count     = q.count;
    assign fire      = q.fire;

endmodule

// *** rtl/src_reset_ctrl.sv ***
// Purpose: System reset controller with open-drain reset pin and cause latch
// Assumes: Pin inputs synchronous to clock except the reset pin, which is synchronised
// Notes:   Registers reached over classic Wishbone; one aligned word each
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module src_reset_ctrl #(
    parameter int WD_CNT_W = src_pkg::WD_CNT_W
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       arst_n,
    // Wishbone slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [src_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [src_pkg::SEL_W-1:0]  wb_sel_i,
    input  wire logic [src_pkg::DATA_W-1:0] wb_dat_i,
    output logic      [src_pkg::DATA_W-1:0] wb_dat_o,
    output logic                            wb_ack_o,
    // Reset sources
    input  wire logic                       powerOnResetPinN,
    input  wire logic                       lowVoltageDetect,
    // Open-drain reset pin
    input  wire logic                       resetPinIn,
    output logic                            resetPinOut,
    output logic                            resetPinOe,
    // CPU side
    input  wire logic                       nmiReq,
    output logic                            nmiTake,
    output logic                            cpuReset,
    output logic                            abortMemOps,
    output src_pkg::src_cpu_init_t          cpuInit
);

    typedef struct packed {
        logic                           ack;
        logic [src_pkg::DATA_W-1:0]     rdData;
        logic [15:0]                    sysCtrl;
        src_pkg::src_cause_t            cause;
        logic [src_pkg::STRETCH_W-1:0]  stretchCnt;
        logic                           drive;
        logic [src_pkg::DRIVE_DLY_W-1:0] driveDly;
        logic                           pinMeta;
        logic                           pinSync;
        logic                           cpuReset;
        src_pkg::src_cpu_init_t         cpuInit;
    } src_top_state_t;

    // Controller starts in reset so the CPU image is loaded at power-up
    localparam src_top_state_t TOP_RST = '{
        ack:        1'b0,
        rdData:     32'h0000_0000,
        sysCtrl:    src_pkg::SCR_RST,
        cause:      5'h01 << src_pkg::CAUSE_POR,
        stretchCnt: src_pkg::STRETCH_CYCLES,
        drive:      1'b1,
        driveDly:   2'h0,
        pinMeta:    1'b1,
        pinSync:    1'b1,
        cpuReset:   1'b1,
        cpuInit:    src_pkg::CPU_INIT
    };

    src_top_state_t q;
    src_top_state_t d;

    // Watchdog interface
    logic                wdCtrlWrite;
    logic                wdKeyWrite;
    logic [7:0]          wdCtrlValue;
    logic [WD_CNT_W-1:0] wdCount;
    logic                wdFire;

    // Bus decode
    logic                busReq;
    logic                busDo;
    logic                busWrite;
    logic [7:0]          byteAdr;
    logic                hitMapped;

    // Events
    logic                swEvt;
    logic                porLevel;
    logic                illegalEvt;
    logic                pinExt;
    logic                anyEvt;
    src_pkg::src_cause_t newCause;
    src_pkg::src_cause_t clrCause;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    always_comb begin
        byteAdr   = {wb_adr_i[src_pkg::ADDR_W-1:2], 2'b00};
        busReq    = wb_cyc_i & wb_stb_i & ~q.ack;
        // Writes commit on the edge where the master sees ack
        busDo     = wb_cyc_i & wb_stb_i & q.ack;
        busWrite  = busDo & wb_we_i;
        hitMapped = (byteAdr == src_pkg::OFS_SYS_CTRL) || (byteAdr == src_pkg::OFS_CAUSE) ||
                    (byteAdr == src_pkg::OFS_WD_CTRL) || (byteAdr == src_pkg::OFS_WD_KEY) ||
                    (byteAdr == src_pkg::OFS_WD_COUNT) || (byteAdr == src_pkg::OFS_CPU_IMAGE);
    end

    always_comb begin
        wdCtrlWrite = busWrite & wb_sel_i[0] & (byteAdr == src_pkg::OFS_WD_CTRL);
        wdKeyWrite  = busWrite & wb_sel_i[0] & (byteAdr == src_pkg::OFS_WD_KEY);
    end

    src_watchdog #(
        .CNT_W (WD_CNT_W)
    ) u_watchdog (
        .clock     (clock),
        .arst_n    (arst_n),
        .sysReset  (q.cpuReset),
        .ctrlWrite (wdCtrlWrite),
        .keyWrite  (wdKeyWrite),
        .wrData    (wb_dat_i[7:0]),
        .ctrlValue (wdCtrlValue),
        .count     (wdCount),
        .fire      (wdFire)
    );

    always_comb begin
        // Level request: holds until the system reset restores the register
        swEvt      = ~q.sysCtrl[src_pkg::SCR_KEEP_BIT] | q.sysCtrl[src_pkg::SCR_FORCE_BIT];
        porLevel   = ~powerOnResetPinN | lowVoltageDetect;
        illegalEvt = busDo & ~hitMapped;
        // Own drive blinds the sampler; wait out the two-stage lag before trusting it
        pinExt     = ~q.pinSync & ~q.drive & ~(|q.driveDly);
        anyEvt     = wdFire | swEvt | porLevel | illegalEvt | pinExt;

        newCause          = '0;
        newCause.watchdog = wdFire;
        newCause.software = swEvt;
        newCause.powerOn  = porLevel;
        newCause.illegal  = illegalEvt;
        newCause.pin      = pinExt;

        clrCause = '0;
        if (busWrite && wb_sel_i[0] && byteAdr == src_pkg::OFS_CAUSE) begin
            clrCause = wb_dat_i[src_pkg::CAUSE_W-1:0];
        end
    end

    always_comb begin
        d        = q;
        d.ack    = busReq;
        d.rdData = 32'h0000_0000;

        // Two-flop sampler of the shared reset line
        d.pinMeta = resetPinIn;
        d.pinSync = q.pinMeta;

        // Register reads, captured as ack rises
        if (busReq && !wb_we_i) begin
            unique case (byteAdr)
                src_pkg::OFS_SYS_CTRL:  d.rdData = {16'h0000, q.sysCtrl};
                src_pkg::OFS_CAUSE:     d.rdData = 32'(q.cause);
                src_pkg::OFS_WD_CTRL:   d.rdData = {24'h00_0000, wdCtrlValue};
                src_pkg::OFS_WD_COUNT:  d.rdData = 32'(wdCount);
                src_pkg::OFS_CPU_IMAGE: d.rdData = 32'({q.cpuInit.ramBlockMap, q.cpuInit.globalIntMask,
                                                        q.cpuInit.arithWrap, q.cpuInit.extFlagOut,
                                                        q.cpuInit.signExtend, q.cpuInit.productShift,
                                                        q.cpuInit.carry, q.cpuInit.waitStates});
                default:                d.rdData = 32'h0000_0000;
            endcase
        end

        // System control write
        if (busWrite && byteAdr == src_pkg::OFS_SYS_CTRL) begin
            d.sysCtrl = merge16(q.sysCtrl, wb_dat_i, wb_sel_i);
        end

        // Cause latch: write-one-to-clear, a new event wins over the clear
        d.cause = (q.cause & ~clrCause) | newCause;
        if (porLevel) begin
            d.cause = newCause;
        end

        // Stretch: every event reloads, so level sources keep the pin low
        if (anyEvt) begin
            d.stretchCnt = src_pkg::STRETCH_CYCLES;
        end else if (q.stretchCnt != '0) begin
            d.stretchCnt = q.stretchCnt - 1'b1;
        end
        d.drive    = (d.stretchCnt != '0);
        d.driveDly = {q.driveDly[0], q.drive};

        // Internal reset also covers the blind window after our own drive ends
        d.cpuReset = anyEvt | d.drive | (|q.driveDly);

        // System reset reinitialises control state; RAM is not touched here
        if (q.cpuReset) begin
            d.sysCtrl = src_pkg::SCR_RST;
            d.cpuInit = src_pkg::CPU_INIT;
            d.cpuInit.progCounter    = 16'h0000;
            d.cpuInit.ramBlockMap    = 1'b0;
            d.cpuInit.globalIntMask  = 1'b1;
            d.cpuInit.intFlag        = 16'h0000;
            d.cpuInit.intMask        = 16'h0000;
            d.cpuInit.arithWrap      = 1'b0;
            d.cpuInit.extFlagOut     = 1'b1;
            d.cpuInit.signExtend     = 1'b1;
            d.cpuInit.productShift   = 2'h0;
            d.cpuInit.carry          = 1'b1;
            d.cpuInit.globalMemAlloc = 8'h00;
            d.cpuInit.repeatCounter  = 16'h0000;
            d.cpuInit.waitStates     = src_pkg::WAIT_MAX;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            q <= TOP_RST;
        end else begin
            q <= d;
        end
    end

    // Bus answers
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdData;

    // Open-drain: only ever pulls low
    assign resetPinOut = 1'b0;
    assign resetPinOe  = q.drive;

    // Reset outranks NMI; NMI carries no abort and no status load
    assign cpuReset    = q.cpuReset;
    assign abortMemOps = q.cpuReset;
    assign nmiTake     = nmiReq & ~q.cpuReset;

    // Only the listed fields are loaded; accumulator and pointers have no image
    assign cpuInit     = q.cpuInit;

endmodule

// *** test/src_reset_ctrl_asserts.sv ***
// Purpose: Concurrent checks on the reset controller ports
// Assumes: One clock domain, arst_n active low
// Notes:   Bound to every src_reset_ctrl instance
`timescale 1ns/1ps
module src_reset_ctrl_asserts #(
    parameter int WD_CNT_W = src_pkg::WD_CNT_W
) (
    // Clock and reset
    input wire logic                   clock,
    input wire logic                   arst_n,
    // Bus handshake
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_ack_o,
    // Sources and pin
    input wire logic                   powerOnResetPinN,
    input wire logic                   lowVoltageDetect,
    input wire logic                   resetPinIn,
    input wire logic                   resetPinOe,
    // CPU side
    input wire logic                   nmiReq,
    input wire logic                   nmiTake,
    input wire logic                   cpuReset,
    input wire logic                   abortMemOps,
    input wire src_pkg::src_cpu_init_t cpuInit
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    chk_pin_stretch: assert property ($rose(resetPinOe) |-> resetPinOe[*8])
        else $error("reset pin released early");
    chk_cpu_with_pin: assert property ($rose(resetPinOe) |-> cpuReset)
        else $error("cpu reset not raised with pin drive");
    chk_cpu_tail: assert property ($fell(resetPinOe) |-> cpuReset[*2])
        else $error("cpu reset ended before pin tail");
    chk_abort_mem: assert property (abortMemOps == cpuReset)
        else $error("memory abort differs from reset");
    chk_nmi_gate: assert property (nmiTake == (nmiReq && !cpuReset))
        else $error("nmi taken wrongly");
    chk_cpu_image: assert property (cpuReset |-> cpuInit == src_pkg::CPU_INIT)
        else $error("cpu reset image wrong");
    chk_supply_hold: assert property (!powerOnResetPinN || lowVoltageDetect |=> resetPinOe && cpuReset)
        else $error("supply fault not holding reset");
    chk_ext_pin: assert property ((!resetPinIn)[*4] |=> cpuReset)
        else $error("external low not seen");
    chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack timing wrong");

    cov_pin_drive: cover property ($rose(resetPinOe));
    cov_nmi_taken: cover property (nmiTake);
    cov_ext_low: cover property ((!resetPinIn)[*4] ##1 !resetPinOe);
endmodule

bind src_reset_ctrl src_reset_ctrl_asserts #(.WD_CNT_W(WD_CNT_W)) u_chk (
    .clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .powerOnResetPinN(powerOnResetPinN), .lowVoltageDetect(lowVoltageDetect), .resetPinIn(resetPinIn),
    .resetPinOe(resetPinOe), .nmiReq(nmiReq), .nmiTake(nmiTake), .cpuReset(cpuReset),
    .abortMemOps(abortMemOps), .cpuInit(cpuInit));

// *** test/src_line_model.sv ***
// Purpose: Shared open-drain reset line with pull-up and an external driver
// Assumes: Pull-up resistor, so a released line reads high
// Notes:   Pulses start just after a rising edge
`timescale 1ns/1ps
module src_line_model (
    // Clock
    input  wire logic clock,
    // Device side of the line
    input  wire logic resetPinOut,
    input  wire logic resetPinOe,
    output logic      resetPinIn
);
    logic extLow;

    initial extLow = 1'b0;

    // Wired low wins over the pull-up
    assign resetPinIn = !((resetPinOe && !resetPinOut) || extLow);

    // Hold the line low for n whole cycles, one at least
    task automatic pulse(input int n);
        @(posedge clock);
        extLow <= 1'b1;
        repeat (n) @(posedge clock);
        extLow <= 1'b0;
    endtask
endmodule

// *** test/system_reset_controller_bench.sv ***
// Purpose: Self-checking bench for the system reset controller
// Assumes: Classic Wishbone, one-cycle ack, pull-up on the reset line
// Notes:   Watchdog disabled after each reset so tests stay short
`timescale 1ns/1ps
module system_reset_controller_bench;
    logic                   clock = 1'b0;
    logic                   arstN = 1'b0;
    logic                   wbCyc = 1'b0;
    logic                   wbStb = 1'b0;
    logic                   wbWe = 1'b0;
    logic [7:0]             wbAdr = 8'h00;
    logic [3:0]             wbSel = 4'h0;
    logic [31:0]            wbDatI = 32'h0000_0000;
    logic [31:0]            wbDatO;
    logic                   wbAck;
    logic                   porN = 1'b1;
    logic                   lowVdd = 1'b0;
    logic                   pinIn;
    logic                   pinOut;
    logic                   pinOe;
    logic                   nmiReq = 1'b0;
    logic                   nmiTake;
    logic                   cpuReset;
    logic                   abortMem;
    src_pkg::src_cpu_init_t cpuInit;
    logic [31:0]            rd;
    int                     miscompares = 0;
    int                     nCompared = 0;
    int                     cycles = 0;
    int                     k;

    always #25 clock = ~clock;

    src_reset_ctrl dut (
        .clock(clock), .arst_n(arstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .powerOnResetPinN(porN), .lowVoltageDetect(lowVdd), .resetPinIn(pinIn), .resetPinOut(pinOut),
        .resetPinOe(pinOe), .nmiReq(nmiReq), .nmiTake(nmiTake), .cpuReset(cpuReset),
        .abortMemOps(abortMem), .cpuInit(cpuInit));

    src_line_model line (.clock(clock), .resetPinOut(pinOut), .resetPinOe(pinOe), .resetPinIn(pinIn));

    task automatic closeOut();
        $display("compared %0d, miscompares %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Held until ack; data taken at the ack edge only
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= wd;
        wbSel <= 4'hF;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        // A missing ack is a failure, not a silent zero read
        if (wbAck !== 1'b1) begin
            miscompares++;
        end
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    // Waits out a reset, checks its cause, clears it, parks the watchdog
    task automatic settle(input logic [4:0] cause);
        int n;
        n = 0;
        while (cpuReset !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        n = 0;
        while (cpuReset !== 1'b0 && n < 200) begin
            @(posedge clock);
            n++;
        end
        // Stuck in reset counts against the run
        if (cpuReset !== 1'b0) begin
            miscompares++;
        end
        wbXfer(1'b0, src_pkg::OFS_CAUSE, 32'h0000_0000);
        chk("cause", {27'h0, cause}, rd);
        wbXfer(1'b1, src_pkg::OFS_CAUSE, 32'h0000_001F);
        wbXfer(1'b1, src_pkg::OFS_WD_CTRL, 32'h0000_0068);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            closeOut();
        end
    end

    initial begin
        repeat (10) @(posedge clock);
        arstN <= 1'b1;
        settle(5'h04);
        wbXfer(1'b0, src_pkg::OFS_CPU_IMAGE, 32'h0000_0000);
        chk("image", 32'h0000_02CF, rd);
        wbXfer(1'b0, src_pkg::OFS_SYS_CTRL, 32'h0000_0000);
        chk("sysctrl", 32'h0000_4000, rd);
        // Watchdog re-enabled after parking and never kicked must bite with no further software help
        wbXfer(1'b1, src_pkg::OFS_WD_CTRL, 32'h0000_0028);
        k = 0;
        while (pinOe !== 1'b1 && k < 400) begin
            @(posedge clock);
            k++;
        end
        nmiReq <= 1'b1;
        @(negedge clock);
        chk("nmi in reset", 32'h0, {31'h0, nmiTake});
        chk("abort", 32'h1, {31'h0, abortMem});
        chk("pc", 32'h0, {16'h0, cpuInit.progCounter});
        chk("int regs", 32'h0, {cpuInit.intFlag, cpuInit.intMask});
        chk("alloc repeat_counter", 32'h0, {8'h0, cpuInit.globalMemAlloc, cpuInit.repeatCounter});
        chk("line low", 32'h0, {31'h0, pinIn});
        settle(5'h01);
        @(negedge clock);
        chk("nmi taken", 32'h1, {31'h0, nmiTake});
        nmiReq <= 1'b0;
        // Force set, then keep cleared
        for (int i = 0; i < 2; i++) begin
            wbXfer(1'b1, src_pkg::OFS_SYS_CTRL, i == 0 ? 32'h0000_C000 : 32'h0000_0000);
            k = 0;
            while (pinOe !== 1'b1 && k < 10) begin
                @(posedge clock);
                k++;
            end
            k = 0;
            while (pinOe === 1'b1 && k < 40) begin
                @(posedge clock);
                k++;
            end
            chk("stretch", 32'h1, {31'h0, k >= 8 && k <= 12});
            settle(5'h02);
        end
        wbXfer(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'h0, rd);
        settle(5'h08);
        wbXfer(1'b1, src_pkg::OFS_WD_KEY, 32'h0000_0012);
        settle(5'h01);
        wbXfer(1'b1, src_pkg::OFS_WD_CTRL, 32'h0000_0000);
        settle(5'h01);
        wbXfer(1'b1, src_pkg::OFS_WD_KEY, 32'h0000_0055);
        wbXfer(1'b1, src_pkg::OFS_WD_KEY, 32'h0000_00AA);
        // A bite shows on cpuReset one edge after the key commit
        repeat (3) @(posedge clock);
        chk("good key", 32'h0, {31'h0, cpuReset});
        wbXfer(1'b0, src_pkg::OFS_WD_COUNT, 32'h0000_0000);
        chk("wd count", 32'h0, rd);
        line.pulse(1);
        settle(5'h10);
        // Long external low: reset must not drop while the line is held
        fork
            line.pulse(40);
        join_none
        repeat (5) @(posedge clock);
        k = 0;
        repeat (30) begin
            @(posedge clock);
            k += (cpuReset !== 1'b1);
        end
        chk("pin hold", 32'h0, k);
        settle(5'h10);
        // Mid-run asynchronous reset reloads the power-on cause
        arstN <= 1'b0;
        repeat (2) @(posedge clock);
        arstN <= 1'b1;
        settle(5'h04);
        // Power-on pin, then low supply, held well past the stretch
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            porN <= (i != 0);
            lowVdd <= (i == 1);
            repeat (30) @(posedge clock);
            chk("held", 32'h1, {31'h0, pinOe});
            porN <= 1'b1;
            lowVdd <= 1'b0;
            settle(5'h04);
        end
        closeOut();
    end
endmodule
